//--- common/src_pkg.sv
// package with register map, field positions, reset values and timing for the reset control block
// Functional notes
// - five reset causes accepted
// - power-on resets core, peripherals, test port
// - pin reset spares test port logic
// - brown-out acts as pin reset while low; here it does not reset the tap pin config
// - brown-out reset disabled until enabled
// - brown-out gives interrupt or reset
// - three peripheral reset registers, set then clear
// - reset bits match clock gating positions
// - all clock domains of unit reset
// - core request resets system, then boots
// - watchdog resets core and peripherals only
// - cause bits set, sticky across resets
// - power-on clears other cause bits
// - hold reset until power-on detect ends
// - boot fetches stack, counter, instruction
// - read-only identification registers provided
// - watchdog second time-out resets system
package src_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_IDENT0     = 12'h000;
  localparam logic [11:0] OFS_IDENT1     = 12'h004;
  localparam logic [11:0] OFS_CAP0       = 12'h008;
  localparam logic [11:0] OFS_CAP4       = 12'h018;
  localparam logic [11:0] OFS_BROWNOUT   = 12'h030;
  localparam logic [11:0] OFS_CAUSE      = 12'h05c;
  localparam logic [11:0] OFS_SOFT0      = 12'h040;
  localparam logic [11:0] OFS_SOFT1      = 12'h044;
  localparam logic [11:0] OFS_SOFT2      = 12'h048;
  localparam logic [11:0] OFS_STATUS     = 12'h050;
  // brownout control fields
  localparam int BIT_BO_RESET_EN = 1;
  localparam int BIT_BO_INT_EN   = 2;
  // cause register fields
  localparam int BIT_CAUSE_PIN   = 0;
  localparam int BIT_CAUSE_POR   = 1;
  localparam int BIT_CAUSE_BROWNOUT = 2;
  localparam int BIT_CAUSE_WDT   = 3;
  localparam int BIT_CAUSE_SW    = 4;
  localparam int CAUSE_W         = 5;
  // status register fields
  localparam int BIT_ST_BROWNOUT = 0;
  localparam int BIT_ST_BOOT     = 1;
  // reset values
  localparam logic [31:0] RST_BROWNOUT = 32'h0000_0000;
  localparam logic [31:0] RST_SOFT     = 32'h0000_0000;
  localparam logic [4:0]  RST_CAUSE    = 5'h00;
  // timing: internal reset held for at least this after a source ends
  localparam int HOLD_NS     = 200;
  localparam int CLK_NS      = 20;
  localparam int HOLD_CYCLES = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int BOOT_STEPS  = 3;
  localparam int NUM_SOFT    = 3;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    SEQ_HOLD    = 4'b0001,
    SEQ_STACK   = 4'b0010,
    SEQ_COUNTER = 4'b0100,
    SEQ_RUN     = 4'b1000
  } src_seq_type;
endpackage : src_pkg

//--- common/src_soft_if.sv
// interface carrying per-peripheral software reset pulses between modules
`timescale 1ns/1ps
`default_nettype none
interface src_soft_if #(parameter int W = 32);
  logic [W-1:0] set_bits;   // bits written by software
  logic [W-1:0] rst_pulse;  // reset while bit set and one cycle after it clears
  modport ctl (input set_bits, output rst_pulse);
  modport usr (output set_bits, input rst_pulse);
endinterface : src_soft_if
`default_nettype wire

//--- rtl/src_sync.sv
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module src_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] rst_val_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta; // first stage, read only by q_o
  // plain two-stage capture; reset clears both stages to zero for every bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
  // rst_val_i kept for callers that want a polarity hint; not stored
  logic unused_rst_val;
  assign unused_rst_val = ^rst_val_i;
endmodule : src_sync
`default_nettype wire

//--- rtl/src_soft_pulse.sv
// stretcher turning software bits into a reset held while set and one cycle after clear
`timescale 1ns/1ps
`default_nettype none
module src_soft_pulse #(
  parameter int W = 32
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  src_soft_if.ctl   sif
);
  logic [W-1:0] prev; // last cycle's software bits
  // a peripheral is held in reset while its bit is set and for one cycle after it clears
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev <= '0;
    end else begin
      prev <= sif.set_bits;
    end
  end
  // while the bit is high the unit is held too, so all its domains see reset
  assign sif.rst_pulse = prev | sif.set_bits;
endmodule : src_soft_pulse
`default_nettype wire

//--- rtl/src_reset_ctrl.sv
// reset control top: source merge, release sequencer, cause record and APB registers
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module src_reset_ctrl #(
  parameter int          PW     = 32,             // peripherals per soft reset register
  parameter logic [31:0] IDENT0 = 32'h1234_0001,  // arbitrary neutral value
  parameter logic [31:0] IDENT1 = 32'h5678_0002,  // arbitrary neutral value
  parameter logic [31:0] CAP0   = 32'h0000_00ff   // arbitrary feature word
) (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  // reset sources
  input  wire logic               ext_reset_n_i,     // board reset pin, active low
  input  wire logic               power_on_detect_i, // high while supply ramps
  input  wire logic               brownout_detect_i, // high while supply below threshold
  input  wire logic               system_reset_request_i, // core request, same clock
  input  wire logic               watchdog_reset_i,  // second time-out, same clock
  input  wire logic               test_mode_pin0_i,
  input  wire logic               test_mode_pin1_i,
  // apb slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [11:0]        paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // reset outputs, active low; brownout interrupt active high
  output logic                    core_reset_n_o,
  output logic                    periph_reset_n_o,
  output logic                    tap_reset_n_o,
  output logic                    tap_pin_cfg_reset_n_o,
  output logic [3*PW-1:0]         periph_unit_reset_n_o,
  output logic                    brownout_irq_o,
  // boot fetch steps
  output src_pkg::src_seq_type    boot_state_o,
  output logic                    fetch_stack_o,
  output logic                    fetch_counter_o,
  output logic                    run_o
);
  import src_pkg::*;

  // local reset released through two flops
  logic [1:0] rst_pipe;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // pin and detector inputs cross into the clock domain
  logic [2:0] async_in;
  logic [2:0] sync_q;
  logic       pin_low;     // synchronised pin asserted
  logic       por_act;     // synchronised power-on detect
  logic       bo_act;      // synchronised brownout level
  assign async_in = {brownout_detect_i, power_on_detect_i, ~ext_reset_n_i};
  src_sync #(.W(3)) u_sync (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n),
    .rst_val_i (3'b000),
    .d_i       (async_in),
    .q_o       (sync_q)
  );
  assign pin_low = sync_q[0];
  assign por_act = sync_q[1];
  assign bo_act  = sync_q[2];

  // test mode pins have no function; read them so nothing floats
  logic unused_test;
  assign unused_test = test_mode_pin0_i | test_mode_pin1_i;

  // registers written by software
  logic [31:0] brownout_ctrl_reg;
  logic [31:0] soft_reg [NUM_SOFT];
  logic [CAUSE_W-1:0] reset_cause_reg;
  logic        brownout_reset_enable;
  assign brownout_reset_enable = brownout_ctrl_reg[BIT_BO_RESET_EN];

  // merged system reset request from all system-wide sources
  logic bo_reset;     // brownout reset path gated by enable
  logic sys_src;      // any source that resets core and peripherals
  assign bo_reset = bo_act & brownout_reset_enable;
  assign sys_src  = pin_low | por_act | bo_reset
                  | system_reset_request_i | watchdog_reset_i;
  assign brownout_irq_o = bo_act & brownout_ctrl_reg[BIT_BO_INT_EN];

  // hold counter keeps internal reset after every source ends
  logic [7:0] hold_cnt;
  logic       hold_done;
  assign hold_done = (hold_cnt == 8'(HOLD_CYCLES));
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 8'h00;
    end else if (sys_src) begin
      hold_cnt <= 8'h00;
    end else if (!hold_done) begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end

  // boot sequencer: hold, fetch stack, fetch counter, run
  src_seq_type state;
  src_seq_type next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      SEQ_HOLD:    if (hold_done && !sys_src) next_state = SEQ_STACK;
      SEQ_STACK:   next_state = sys_src ? SEQ_HOLD : SEQ_COUNTER;
      SEQ_COUNTER: next_state = sys_src ? SEQ_HOLD : SEQ_RUN;
      SEQ_RUN:     if (sys_src) next_state = SEQ_HOLD;
      default:     next_state = SEQ_HOLD;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= SEQ_HOLD;
    end else begin
      state <= next_state;
    end
  end
  assign boot_state_o    = state;
  assign fetch_stack_o   = (state == SEQ_STACK);
  assign fetch_counter_o = (state == SEQ_COUNTER);
  assign run_o           = (state == SEQ_RUN);

  // domain resets: core and peripherals follow the sequencer, tap only power-on, tap pin config power-on or pin
  logic in_reset;
  assign in_reset = (state == SEQ_HOLD);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      core_reset_n_o        <= 1'b0;
      periph_reset_n_o      <= 1'b0;
      tap_reset_n_o         <= 1'b0;
      tap_pin_cfg_reset_n_o <= 1'b0;
    end else begin
      core_reset_n_o        <= ~in_reset;
      periph_reset_n_o      <= ~in_reset;
      tap_reset_n_o         <= ~por_act;
      tap_pin_cfg_reset_n_o <= ~(por_act | pin_low);
    end
  end

  // per-peripheral software resets, same bit positions as clock gating
  src_soft_if #(.W(3*PW)) sif ();
  genvar g;
  for (g = 0; g < NUM_SOFT; g++) begin : g_soft
    assign sif.set_bits[g*PW +: PW] = soft_reg[g][PW-1:0];
  end
  src_soft_pulse #(.W(3*PW)) u_soft (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .sif     (sif)
  );
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      periph_unit_reset_n_o <= '0;
    end else begin
      periph_unit_reset_n_o <= ~(sif.rst_pulse | {3*PW{in_reset}});
    end
  end

  // apb decode
  logic wr_en;
  logic rd_sel;
  logic hit;
  assign wr_en  = psel_i & penable_i & pwrite_i;
  assign rd_sel = psel_i & ~pwrite_i;
  assign hit = (paddr_i == OFS_IDENT0) || (paddr_i == OFS_IDENT1)
            || (paddr_i >= OFS_CAP0 && paddr_i <= OFS_CAP4 && paddr_i[1:0] == 2'b00)
            || (paddr_i == OFS_BROWNOUT) || (paddr_i == OFS_CAUSE)
            || (paddr_i == OFS_SOFT0) || (paddr_i == OFS_SOFT1)
            || (paddr_i == OFS_SOFT2) || (paddr_i == OFS_STATUS);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;

  // cause events, sampled on the rising edge of each source
  logic [CAUSE_W-1:0] src_now;
  logic [CAUSE_W-1:0] src_prev;
  logic [CAUSE_W-1:0] src_rise;
  assign src_now = {system_reset_request_i, watchdog_reset_i, bo_reset, por_act, pin_low};
  assign src_rise = src_now & ~src_prev;
  logic cause_wr;
  assign cause_wr = wr_en && (paddr_i == OFS_CAUSE);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      src_prev <= '0;
    end else begin
      src_prev <= src_now;
    end
  end
  // cause register lives outside the system reset; set wins over software clear
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reset_cause_reg <= RST_CAUSE;
    end else if (src_rise[BIT_CAUSE_POR]) begin
      reset_cause_reg <= CAUSE_W'(1) << BIT_CAUSE_POR;
    end else if (cause_wr) begin
      reset_cause_reg <= (reset_cause_reg & pwdata_i[CAUSE_W-1:0]) | src_rise;
    end else begin
      reset_cause_reg <= reset_cause_reg | src_rise;
    end
  end

  // control register writes; these survive system resets by design
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      brownout_ctrl_reg <= RST_BROWNOUT;
      for (int i = 0; i < NUM_SOFT; i++) soft_reg[i] <= RST_SOFT;
    end else if (wr_en) begin
      if (paddr_i == OFS_BROWNOUT) brownout_ctrl_reg <= pwdata_i & 32'h0000_0006;
      if (paddr_i == OFS_SOFT0) soft_reg[0] <= pwdata_i;
      if (paddr_i == OFS_SOFT1) soft_reg[1] <= pwdata_i;
      if (paddr_i == OFS_SOFT2) soft_reg[2] <= pwdata_i;
    end
  end

  // read mux; identification words are constants
  logic [31:0] rd_mux;
  assign rd_mux = (paddr_i == OFS_IDENT0)   ? IDENT0 :
                  (paddr_i == OFS_IDENT1)   ? IDENT1 :
                  (paddr_i == OFS_CAP0)     ? CAP0 :
                  (paddr_i == OFS_BROWNOUT) ? brownout_ctrl_reg :
                  (paddr_i == OFS_CAUSE)    ? {27'h0, reset_cause_reg} :
                  (paddr_i == OFS_SOFT0)    ? soft_reg[0] :
                  (paddr_i == OFS_SOFT1)    ? soft_reg[1] :
                  (paddr_i == OFS_SOFT2)    ? soft_reg[2] :
                  (paddr_i == OFS_STATUS)   ? {30'h0, run_o, bo_act} :
                  32'h0000_0000;
  // read data registered at setup so it is stable in the access phase
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_sel && !penable_i) begin
      prdata_o <= rd_mux;
    end
  end

  // assertions
  property p_tap_kept;
    @(posedge clk_i) disable iff (!rst_n)
      (!por_act && $past(!por_act)) |=> tap_reset_n_o;
  endproperty
  a_tap_kept: assert property (p_tap_kept) else $error("tap reset without power-on");

  // a disabled brownout must not knock a running core back into reset
  property p_bo_gated;
    @(posedge clk_i) disable iff (!rst_n)
      (run_o && bo_act && !brownout_reset_enable && !pin_low && !por_act
       && !system_reset_request_i && !watchdog_reset_i) |=> run_o;
  endproperty
  a_bo_gated: assert property (p_bo_gated) else $error("brownout reset while disabled");

  property p_sys_hold;
    @(posedge clk_i) disable iff (!rst_n)
      sys_src |=> ##1 !core_reset_n_o;
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("core not reset by source");

  property p_boot_order;
    @(posedge clk_i) disable iff (!rst_n)
      (fetch_stack_o && !sys_src) |=> fetch_counter_o;
  endproperty
  a_boot_order: assert property (p_boot_order) else $error("boot order broken");

  property p_hold_por;
    @(posedge clk_i) disable iff (!rst_n)
      por_act |=> (state == SEQ_HOLD);
  endproperty
  a_hold_por: assert property (p_hold_por) else $error("released during power-on");

  property p_por_only;
    @(posedge clk_i) disable iff (!rst_n)
      src_rise[BIT_CAUSE_POR] |=> (reset_cause_reg == (CAUSE_W'(1) << BIT_CAUSE_POR));
  endproperty
  a_por_only: assert property (p_por_only) else $error("power-on cause not alone");

  property p_cause_sticky;
    @(posedge clk_i) disable iff (!rst_n)
      (src_rise[BIT_CAUSE_WDT] && !src_rise[BIT_CAUSE_POR]) |=> reset_cause_reg[BIT_CAUSE_WDT];
  endproperty
  a_cause_sticky: assert property (p_cause_sticky) else $error("watchdog cause lost");

  // every unit whose bit was set is held two cycles later, and the core runs on
  property p_soft_unit;
    @(posedge clk_i) disable iff (!rst_n)
      (|sif.set_bits && !in_reset && !sys_src) |=> ##1
        ((($past(sif.set_bits, 2) & periph_unit_reset_n_o) == '0) && core_reset_n_o);
  endproperty
  a_soft_unit: assert property (p_soft_unit) else $error("soft reset wrong scope");

  property p_wdt_release;
    @(posedge clk_i) disable iff (!rst_n)
      $fell(sys_src) |-> ##[1:40] fetch_stack_o;
  endproperty
  a_wdt_release: assert property (p_wdt_release) else $error("no boot after release");

  c_por:  cover property (@(posedge clk_i) disable iff (!rst_n) $fell(por_act) ##[1:40] run_o);
  c_wdt:  cover property (@(posedge clk_i) disable iff (!rst_n) watchdog_reset_i ##[1:40] run_o);
  c_bo:   cover property (@(posedge clk_i) disable iff (!rst_n) bo_reset);
  c_soft: cover property (@(posedge clk_i) disable iff (!rst_n) $fell(soft_reg[1][3]));
endmodule : src_reset_ctrl
`default_nettype wire

//--- tb/src_board_model.sv
// board, supply monitor, watchdog and core request model driving the reset sources
`timescale 1ns/1ps
`default_nettype none
module src_board_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,          // start one source event
  input  wire logic [2:0] kind_i,        // source index, same order as the cause bits
  input  wire logic [7:0] len_i,         // cycles the source stays active
  output logic            ext_reset_n_o, // board pin, active low
  output logic            power_on_o,    // supply ramp detector
  output logic            brownout_o,    // supply under threshold
  output logic            sysreq_o,      // core system request
  output logic            wdog_o,        // watchdog second time-out
  output logic            tmode0_o,      // test mode pin 0
  output logic            tmode1_o       // test mode pin 1
);
  logic [7:0] cnt  = 8'h00; // remaining active cycles
  logic [2:0] kind = 3'h0;  // latched source
  wire        act  = (cnt != 8'h00);
  // count down the event; a long length models a slow board or supply
  always @(posedge clk_i) begin
    if (go_i) begin
      cnt  <= len_i;
      kind <= kind_i;
    end else if (act) begin
      cnt <= cnt - 8'h01;
    end
  end
  // each source is a clean level for the whole length, nothing else moves
  assign ext_reset_n_o = !(act && kind == 3'h0);
  assign power_on_o    = act && kind == 3'h1;
  assign brownout_o    = act && kind == 3'h2;
  assign wdog_o        = act && kind == 3'h3;
  assign sysreq_o      = act && kind == 3'h4;
  // manufacturing pins have no user function, so the board grounds them
  assign tmode0_o      = 1'b0;
  assign tmode1_o      = 1'b0;
endmodule // src_board_model
`default_nettype wire

//--- tb/system_reset_control_test.sv
// self-checking bench for the reset control block
`timescale 1ns/1ps
`default_nettype none
module system_reset_control_test;
  import src_pkg::*;
  logic        clk_i = 1'b0;     // system clock, 50 MHz
  logic        resetn_i = 1'b0;  // bench reset, active low
  logic        psel = 1'b0;      // apb select
  logic        penable = 1'b0;   // apb access phase
  logic        pwrite = 1'b0;    // apb direction
  logic [11:0] paddr = 12'h000;  // apb address
  logic [31:0] pwdata = 32'h0;   // apb write data
  logic        go = 1'b0;        // partner event start
  logic [2:0]  kind = 3'h0;      // partner event source
  logic [7:0]  len = 8'h00;      // partner event length
  logic        ext_n, por, bod, sreq, wdog, tm0, tm1;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, core_n, per_n, tap_n, pin_n, irq, stk, ctr, run;
  logic [95:0] unit_n;
  src_seq_type st;
  logic [32:0] exp_q[$];         // expected {slave error, read data}
  int          err_count = 0;
  int          samples_checked = 0;
  int          seed = 16226;
  logic [4:0]  cause = 5'h00;    // expected cause record
  logic [31:0] bo_ctrl = 32'h0;  // brownout control as written
  int          k;

  // free-running system clock, 20 ns period
  initial begin
    forever #10 clk_i = !clk_i;
  end

  src_board_model brd (.clk_i(clk_i), .go_i(go), .kind_i(kind), .len_i(len),
    .ext_reset_n_o(ext_n), .power_on_o(por), .brownout_o(bod), .sysreq_o(sreq),
    .wdog_o(wdog), .tmode0_o(tm0), .tmode1_o(tm1));

  src_reset_ctrl dut (.clk_i(clk_i), .resetn_i(resetn_i), .ext_reset_n_i(ext_n),
    .power_on_detect_i(por), .brownout_detect_i(bod), .system_reset_request_i(sreq),
    .watchdog_reset_i(wdog), .test_mode_pin0_i(tm0), .test_mode_pin1_i(tm1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .core_reset_n_o(core_n), .periph_reset_n_o(per_n), .tap_reset_n_o(tap_n),
    .tap_pin_cfg_reset_n_o(pin_n), .periph_unit_reset_n_o(unit_n),
    .brownout_irq_o(irq), .boot_state_o(st), .fetch_stack_o(stk),
    .fetch_counter_o(ctr), .run_o(run));

  // compare one result and count it
  task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; a read leaves its expectation for the monitor
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(exp);
    @(posedge clk_i);
    penable <= 1'b1;
    // hold everything until pready is seen high; only the bench watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // monitor: a completed read takes the oldest expectation
  always @(posedge clk_i) begin
    if (psel && penable && !pwrite && pready_o === 1'b1 && exp_q.size() > 0) begin
      chk("prdata", {63'h0, exp_q.pop_front()}, {63'h0, pslverr_o, prdata_o});
    end
  end

  // wait for release, then stack, counter and run on successive cycles
  task automatic boot_wait();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (stk !== 1'b1 && n < 80);
    chk("fetch_stack", 1, stk);
    @(posedge clk_i);
    #1 chk("fetch_counter", 1, ctr);
    @(posedge clk_i);
    #1 chk("run", {3'h7, SEQ_RUN}, {run, core_n, per_n, st});
  endtask

  // fire one source and check which domains go into reset
  task automatic src_event(input int kd, input int ln, input logic resets);
    @(posedge clk_i);
    go <= 1'b1;
    kind <= kd[2:0];
    len <= ln[7:0];
    @(posedge clk_i);
    go <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1 chk("core_periph", {2{!resets}}, {core_n, per_n});
    chk("tap", (kd != 1), tap_n);
    chk("tap_pin_cfg", !resets || kd > 1, pin_n);
    chk("irq", kd == 2 && bo_ctrl[BIT_BO_INT_EN], irq);
    if (resets) begin
      boot_wait();
      cause = (kd == 1) ? 5'h02 : (cause | (5'h01 << kd));
      apb(1'b0, OFS_CAUSE, 32'h0, {28'h0, cause});
    end
  endtask

  // closing verdict
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    boot_wait();
    apb(1'b0, OFS_IDENT0, 32'h0, {1'b0, 32'h1234_0001});
    apb(1'b0, OFS_IDENT1, 32'h0, {1'b0, 32'h5678_0002});
    apb(1'b0, 12'h00c, 32'h0, 33'h0);
    apb(1'b0, OFS_BROWNOUT, 32'h0, {1'b0, RST_BROWNOUT});
    apb(1'b0, OFS_CAUSE, 32'h0, 33'h0);
    apb(1'b0, 12'h100, 32'h0, {1'b1, 32'h0});
    apb(1'b0, OFS_STATUS, 32'h0, {1'b0, 32'h0000_0002});
    // brownout with interrupt only: no reset
    bo_ctrl = 32'h4;
    apb(1'b1, OFS_BROWNOUT, bo_ctrl, 33'h0);
    src_event(2, 12, 1'b0);
    src_event(1, 12, 1'b1);
    src_event(0, 12, 1'b1);
    apb(1'b1, OFS_BROWNOUT, 32'hffff_ffff, 33'h0);
    apb(1'b0, OFS_BROWNOUT, 32'h0, {1'b0, 32'h6});
    bo_ctrl = 32'h6;
    src_event(2, 12, 1'b1);
    src_event(3, 1, 1'b1);
    src_event(4, 1, 1'b1);
    // one random unit in each soft reset register: set, hold, clear
    for (int r = 0; r < NUM_SOFT; r++) begin
      k = $unsigned($random(seed)) % 32;
      apb(1'b1, OFS_SOFT0 + 12'(4 * r), 32'h1 << k, 33'h0);
      repeat (2) @(posedge clk_i);
      #1 chk("unit", ~(96'h1 << (32 * r + k)), unit_n);
      chk("others", 3'h7, {core_n, per_n, tap_n});
      apb(1'b0, OFS_SOFT0 + 12'(4 * r), 32'h0, {1'b0, 32'h1 << k});
      apb(1'b1, OFS_SOFT0 + 12'(4 * r), 32'h0, 33'h0);
      repeat (3) @(posedge clk_i);
      #1 chk("unit_release", {96{1'b1}}, unit_n);
    end
    src_event(1, 12, 1'b1);
    final_report();
  end
endmodule // system_reset_control_test
`default_nettype wire
